// *** design/mil_pkg.sv ***
/*
  shared constants of the interrupt gating logic: register indexes,
  field positions, reset values and the service vector.
  assumes registers sit on a 32-bit bus at byte address 4 * index.
*/
package mil_pkg;
  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h0b;
  localparam logic [7:0] IDX_FLAGS1 = 8'h0c;
  localparam logic [7:0] IDX_FLAGS2 = 8'h0d;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_EN1 = 8'h8c;
  localparam logic [7:0] IDX_EN2 = 8'h8d;
  localparam logic [7:0] IDX_STATUS = 8'h90;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  // irq_control fields
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_T0E = 5;
  localparam int B_XE = 4;
  localparam int B_PCE = 3;
  localparam int B_T0F = 2;
  localparam int B_XF = 1;
  localparam int B_PCF = 0;
  // timer_edge_config field
  localparam int B_EDGE = 6;
  // periph_irq_flags_1 fields
  localparam int P1_CONV = 6;
  localparam int P1_CMP = 5;
  localparam int P1_CCP = 2;
  localparam int P1_T2M = 1;
  localparam int P1_T1OV = 0;
  // service vector and bus answers
  localparam logic [12:0] VEC_ADDR = 13'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/mil_interrupt_logic.sv ***
/*
  interrupt gating logic of a small 8-bit controller: flags, enables,
  global enable handling, vectoring and wake-up, with an AXI4-Lite
  register slave.
  assumes the core, timer, pin-change and peripheral units share mclk
  and deliver one-cycle event pulses; only the edge pin is asynchronous.
*/
`timescale 1ns/1ps
module mil_interrupt_logic
  import mil_pkg::*;
#(
  parameter int AW = 12,
  parameter int NPIN = 6,
  parameter int EXT_PIN = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extIrqPin,
  input wire logic [NPIN-1:0] pinAnalog,
  input wire logic [NPIN-1:0] pinChangeDetect,
  input wire logic timerOverflow,
  input wire logic [7:0] periphEvent1,
  input wire logic [7:0] periphEvent2,
  input wire logic coreSleeping,
  input wire logic returnFromIrq,
  output logic irqRequest,
  output logic serviceStart,
  output logic [12:0] vectorAddr,
  output logic wakeUp
);

  // elaboration checks: index field needs bits 9..2, pin must exist
  if (AW < 10) begin : g_aw_check
    $error("AW must be at least 10");
  end
  if (EXT_PIN >= NPIN) begin : g_pin_check
    $error("EXT_PIN must be below NPIN");
  end

  logic awHeld;
  logic wHeld;
  logic next_awHeld;
  logic next_wHeld;
  logic [AW-1:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  logic wrFire;
  logic [7:0] wrIdx;
  logic wrMapped;
  logic wrCtrl;
  logic wrFlags1;
  logic wrFlags2;
  logic wrOption;
  logic wrEn1;
  logic wrEn2;
  logic [7:0] rdByte;
  logic rdMapped;
  logic pinSync1;
  logic pinSync2;
  logic pinPrev;
  logic [2:0] pinArm;
  logic extEdge;
  logic pcEvent;
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic timerEnable;
  logic extEnable;
  logic pinChangeEnable;
  logic timerFlag;
  logic extFlag;
  logic pinChangeFlag;
  logic [7:0] flags1;
  logic [7:0] flags2;
  logic [7:0] enables1;
  logic [7:0] enables2;
  logic [7:0] optionReg;
  logic anyEnabled;
  logic gieWriteClear;
  logic next_service;

  // write channel capture: address and data may come in either order
  assign wrFire = awHeld & wHeld & ~s_axi_bvalid;
  assign next_awHeld = wrFire ? 1'b0 : (awHeld | (s_axi_awvalid & s_axi_awready));
  assign next_wHeld = wrFire ? 1'b0 : (wHeld | (s_axi_wvalid & s_axi_wready));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awAddr <= '0;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      s_axi_awready <= ~next_awHeld;
      s_axi_wready <= ~next_wHeld;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
    end
  end

  // write decode; a cleared lane 0 strobe leaves the register alone
  assign wrIdx = awAddr[9:2];
  assign wrMapped = (awAddr[1:0] == 2'h0) && (awAddr[AW-1:10] == '0) &&
    (wrIdx == IDX_CTRL || wrIdx == IDX_FLAGS1 || wrIdx == IDX_FLAGS2 ||
     wrIdx == IDX_OPTION || wrIdx == IDX_EN1 || wrIdx == IDX_EN2 ||
     wrIdx == IDX_STATUS);
  assign wrCtrl = wrFire & wLane0 & wrMapped & (wrIdx == IDX_CTRL);
  assign wrFlags1 = wrFire & wLane0 & wrMapped & (wrIdx == IDX_FLAGS1);
  assign wrFlags2 = wrFire & wLane0 & wrMapped & (wrIdx == IDX_FLAGS2);
  assign wrOption = wrFire & wLane0 & wrMapped & (wrIdx == IDX_OPTION);
  assign wrEn1 = wrFire & wLane0 & wrMapped & (wrIdx == IDX_EN1);
  assign wrEn2 = wrFire & wLane0 & wrMapped & (wrIdx == IDX_EN2);

  // write response, unmapped addresses answer slave error
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; registers are 8 bits, upper bits read zero
  always_comb begin
    rdByte = 8'h00;
    rdMapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[AW-1:10] == '0);
    unique case (s_axi_araddr[9:2])
      IDX_CTRL: rdByte = {global_irq_enable, peripheral_irq_enable, timerEnable, extEnable, pinChangeEnable,
                          timerFlag, extFlag, pinChangeFlag};
      IDX_FLAGS1: rdByte = flags1;
      IDX_FLAGS2: rdByte = flags2;
      IDX_OPTION: rdByte = optionReg;
      IDX_EN1: rdByte = enables1;
      IDX_EN2: rdByte = enables2;
      IDX_STATUS: rdByte = {6'h00, coreSleeping, irqRequest};
      default: rdMapped = 1'b0;
    endcase
  end

  // read channel: one read in flight, answer one cycle after address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rdMapped ? rdByte : 8'h00};
      s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // edge pin synchroniser plus one history stage for edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      pinSync1 <= extIrqPin;
      pinSync2 <= pinSync1;
      pinPrev <= pinSync2;
    end
  end

  // edges count only once the history holds real samples, so a pin
  // parked high through reset does not look like a fresh edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinArm <= 3'h0;
    end else begin
      pinArm <= {pinArm[1:0], 1'b1};
    end
  end

  // edge polarity by edge select; analog pins are muted
  assign extEdge = pinArm[2] & ~pinAnalog[EXT_PIN] &
    (optionReg[B_EDGE] ? (pinSync2 & ~pinPrev) : (~pinSync2 & pinPrev));
  assign pcEvent = |(pinChangeDetect & ~pinAnalog);

  // primary flags: an event in the clearing cycle still wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timerFlag <= CTRL_RST[B_T0F];
      extFlag <= CTRL_RST[B_XF];
      pinChangeFlag <= CTRL_RST[B_PCF];
    end else begin
      timerFlag <= (wrCtrl ? wByte[B_T0F] : timerFlag) | timerOverflow;
      extFlag <= (wrCtrl ? wByte[B_XF] : extFlag) | extEdge;
      pinChangeFlag <= (wrCtrl ? wByte[B_PCF] : pinChangeFlag) | pcEvent;
    end
  end

  // peripheral flags, same set-over-clear treatment
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags1 <= PERIPH_RST;
      flags2 <= PERIPH_RST;
    end else begin
      flags1 <= (wrFlags1 ? wByte : flags1) | periphEvent1;
      flags2 <= (wrFlags2 ? wByte : flags2) | periphEvent2;
    end
  end

  // enables and edge configuration; nothing here moves on wake-up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peripheral_irq_enable <= CTRL_RST[B_PERIPHERAL_IRQ_ENABLE];
      timerEnable <= CTRL_RST[B_T0E];
      extEnable <= CTRL_RST[B_XE];
      pinChangeEnable <= CTRL_RST[B_PCE];
      enables1 <= PERIPH_RST;
      enables2 <= PERIPH_RST;
      optionReg <= OPTION_RST;
    end else begin
      if (wrCtrl) begin
        peripheral_irq_enable <= wByte[B_PERIPHERAL_IRQ_ENABLE];
        timerEnable <= wByte[B_T0E];
        extEnable <= wByte[B_XE];
        pinChangeEnable <= wByte[B_PCE];
      end
      if (wrEn1) begin
        enables1 <= wByte;
      end
      if (wrEn2) begin
        enables2 <= wByte;
      end
      if (wrOption) begin
        optionReg <= wByte;
      end
    end
  end

  // any enabled source, before the global enable
  assign anyEnabled = (timerFlag & timerEnable) | (extFlag & extEnable) |
    (pinChangeFlag & pinChangeEnable) |
    (peripheral_irq_enable & |((flags1 & enables1) | (flags2 & enables2)));

  // a write clearing the global enable beats a request due now
  assign gieWriteClear = wrCtrl & ~wByte[B_GIE];
  assign next_service = global_irq_enable & anyEnabled & ~gieWriteClear;

  // global enable: cleared by service, set by return, else software
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable <= 1'b0;
    end else if (next_service) begin
      global_irq_enable <= 1'b0;
    end else if (returnFromIrq) begin
      global_irq_enable <= 1'b1;
    end else if (wrCtrl) begin
      global_irq_enable <= wByte[B_GIE];
    end
  end

  // core side: request level, service pulse, vector, wake-up level while sleeping
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqRequest <= 1'b0;
      serviceStart <= 1'b0;
      vectorAddr <= VEC_ADDR;
      wakeUp <= 1'b0;
    end else begin
      irqRequest <= global_irq_enable & anyEnabled;
      serviceStart <= next_service;
      vectorAddr <= VEC_ADDR;
      wakeUp <= coreSleeping & anyEnabled;
    end
  end

  // checks on the gating behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_extRise;
    pinArm[2] && optionReg[B_EDGE] && !pinAnalog[EXT_PIN] && !pinSync2 ##1 pinSync2;
  endsequence

  sequence s_serviceNow;
    serviceStart && vectorAddr == VEC_ADDR;
  endsequence

  sequence s_wakeWithGie;
    coreSleeping && global_irq_enable && anyEnabled && !gieWriteClear;
  endsequence

  a_gie_after_reset: assert property (disable iff (1'b0)
    $rose(resetn) |-> !global_irq_enable) else $error("global enable set after reset");
  a_gie_blocks_all: assert property (!global_irq_enable |=> !serviceStart)
    else $error("service taken with global enable clear");
  a_service_clears: assert property (next_service |=> s_serviceNow ##0 !global_irq_enable)
    else $error("service did not vector or clear enable");
  a_return_sets: assert property (returnFromIrq && !next_service |=> global_irq_enable)
    else $error("return did not set global enable");
  a_timer_flag: assert property (timerOverflow |=> timerFlag)
    else $error("timer overflow lost");
  a_deferred_stays: assert property (global_irq_enable && anyEnabled && gieWriteClear
    |=> !serviceStart && anyEnabled) else $error("deferred request lost");
  a_edge_latency: assert property (s_extRise ##0 extEnable && global_irq_enable && !wrFire
    |=> ##1 serviceStart) else $error("edge not serviced in time");
  a_edge_flag: assert property (s_extRise |=> extFlag)
    else $error("rising edge did not set flag");
  a_analog_quiet: assert property (pinAnalog[EXT_PIN] && !extFlag && !wrFire
    |=> !extFlag) else $error("analog pin raised a flag");
  a_wake_pulse: assert property (coreSleeping && extFlag && extEnable
    |=> wakeUp) else $error("enabled edge did not wake core");

  // wake vectoring, peripheral flags, masking and pin history checks
  a_wake_vector: assert property (s_wakeWithGie
    |=> wakeUp ##0 s_serviceNow) else $error("wake-up with global enable did not vector");
  a_periph_flag: assert property (|periphEvent1
    |=> (flags1 & $past(periphEvent1)) == $past(periphEvent1))
    else $error("peripheral event lost");
  a_pc_flag: assert property (pcEvent |=> pinChangeFlag)
    else $error("pin change event lost");
  a_masked_quiet: assert property (!timerEnable && !extEnable && !pinChangeEnable
    && !peripheral_irq_enable |=> !irqRequest) else $error("request with every source masked");
  a_edge_armed: assert property (!pinArm[2] |-> !extEdge)
    else $error("edge seen before pin history filled");
  a_blocked_flag: assert property (!global_irq_enable && extFlag && !wrCtrl |=> extFlag)
    else $error("blocked request dropped its flag");

endmodule // mil_interrupt_logic

// *** tb/mil_core_model.sv ***
/*
  core-side model of the gating logic: counts service entries, loads
  the vector, pulses return-from-irq and sleeps until woken.
  assumes mclk is shared and the bench asks for return and sleep by
  one-cycle pulses on retReq and sleepReq.
*/
`timescale 1ns/1ps
module mil_core_model
  import mil_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic serviceStart,
  input wire logic [12:0] vectorAddr,
  input wire logic wakeUp,
  input wire logic sleepReq,
  input wire logic retReq,
  output logic coreSleeping,
  output logic returnFromIrq,
  output logic [7:0] serviceCount,
  output logic [12:0] pc
);
  // service entry: return push is implied, pc takes the vector
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serviceCount <= 8'h00;
      pc <= 13'h0000;
    end else if (serviceStart) begin
      serviceCount <= serviceCount + 8'h01;
      pc <= vectorAddr;
    end
  end
  // return is a one-cycle pulse; sleep lasts until the wake request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      returnFromIrq <= 1'b0;
      coreSleeping <= 1'b0;
    end else begin
      returnFromIrq <= retReq;
      if (sleepReq) coreSleeping <= 1'b1;
      else if (wakeUp) coreSleeping <= 1'b0;
    end
  end
endmodule // mil_core_model

// *** tb/tb.sv ***
/*
  self-checking bench of the interrupt gating logic over AXI4-Lite.
  assumes the core model on the far side and a 10 MHz mclk.
*/
`timescale 1ns/1ps
module tb
  import mil_pkg::*;
;
  logic mclk = 0, resetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, returnFromIrq, irqRequest, serviceStart, wakeUp, coreSleeping;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic extIrqPin = 0, timerOverflow = 0, sleepReq = 0, retReq = 0;
  logic [5:0] pinAnalog = 0, pinChangeDetect = 0;
  logic [7:0] periphEvent1 = 0, periphEvent2 = 0, serviceCount, base;
  logic [7:0] reqCount = 8'h00;
  logic [12:0] vectorAddr, pc;
  int num_errors = 0, check_count = 0;
  logic [7:0] idxTab [6] = '{IDX_CTRL, IDX_FLAGS1, IDX_FLAGS2, IDX_OPTION, IDX_EN1, IDX_EN2};
  logic [7:0] rstTab [6] = '{CTRL_RST, PERIPH_RST, PERIPH_RST, OPTION_RST, PERIPH_RST,
    PERIPH_RST};

  // free-running clock, 100 ns period
  always #50 mclk = ~mclk;

  // request cycles seen by the core: one per service plus one per deferral
  always @(posedge mclk) begin
    if (irqRequest === 1'b1) reqCount <= reqCount + 8'h01;
  end

  mil_interrupt_logic mil_interrupt_logic_i (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .extIrqPin(extIrqPin),
    .pinAnalog(pinAnalog), .pinChangeDetect(pinChangeDetect), .timerOverflow(timerOverflow),
    .periphEvent1(periphEvent1), .periphEvent2(periphEvent2), .coreSleeping(coreSleeping),
    .returnFromIrq(returnFromIrq), .irqRequest(irqRequest), .serviceStart(serviceStart),
    .vectorAddr(vectorAddr), .wakeUp(wakeUp));

  mil_core_model mil_core_model_i (.mclk(mclk), .resetn(resetn), .serviceStart(serviceStart),
    .vectorAddr(vectorAddr), .wakeUp(wakeUp), .sleepReq(sleepReq), .retReq(retReq),
    .coreSleeping(coreSleeping), .returnFromIrq(returnFromIrq), .serviceCount(serviceCount),
    .pc(pc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // write one register; a lost response leaves r unknown and fails the compare
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'bxx;
    @(posedge mclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        break;
      end
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask

  // read one register and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    r = 2'bxx;
    d = 'x;
    @(posedge mclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(d, {24'h00_0000, ed}, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask

  // one-cycle pulse: 0 timer, 1 periph1, 2 periph2, 3 pin change, 4 return, 5 sleep
  task automatic pulse(input int k, input logic [7:0] b);
    @(posedge mclk);
    timerOverflow <= (k == 0);
    periphEvent1 <= (k == 1) ? b : 8'h00;
    periphEvent2 <= (k == 2) ? b : 8'h00;
    pinChangeDetect <= (k == 3) ? b[5:0] : 6'h00;
    retReq <= (k == 4);
    sleepReq <= (k == 5);
    @(posedge mclk);
    {timerOverflow, retReq, sleepReq} <= 3'b000;
    {periphEvent1, periphEvent2, pinChangeDetect} <= 22'h00_0000;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    cyc(20000);
    num_errors++;
    end_of_test();
  end

  initial begin
    cyc(20);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(idxTab[i], rstTab[i], RESP_OKAY);
    rd(8'h3c, 8'h00, RESP_SLVERR);
    rd(IDX_STATUS, 8'h00, RESP_OKAY);
    wr(8'h3c, 8'h55, RESP_SLVERR);
    $display("test reset done");
    wr(IDX_CTRL, 8'ha0, RESP_OKAY);
    base = serviceCount;
    pulse(0, 8'h00);
    cyc(3);
    chk(serviceCount, base + 8'h01, "timer service");
    chk(pc, VEC_ADDR, "vector");
    rd(IDX_CTRL, 8'h24, RESP_OKAY);
    pulse(4, 8'h00);
    cyc(4);
    chk(serviceCount, base + 8'h02, "flag left set is taken again");
    wr(IDX_CTRL, 8'h20, RESP_OKAY);
    pulse(4, 8'h00);
    cyc(3);
    rd(IDX_CTRL, 8'ha0, RESP_OKAY);
    chk(serviceCount, base + 8'h02, "no service after clean return");
    $display("test timer done");
    wr(IDX_CTRL, 8'h00, RESP_OKAY);
    pulse(1, 8'h40);
    pulse(2, 8'h01);
    cyc(3);
    rd(IDX_FLAGS1, 8'h40, RESP_OKAY);
    rd(IDX_FLAGS2, 8'h01, RESP_OKAY);
    chk(serviceCount, base + 8'h02, "gie off blocks");
    wr(IDX_EN1, 8'h40, RESP_OKAY);
    wr(IDX_CTRL, 8'hc0, RESP_OKAY);
    cyc(3);
    chk(serviceCount, base + 8'h03, "pending taken when enabled");
    wr(IDX_FLAGS1, 8'h00, RESP_OKAY);
    wr(IDX_FLAGS2, 8'h00, RESP_OKAY);
    $display("test peripheral done");
    wr(IDX_CTRL, 8'h90, RESP_OKAY);
    @(posedge mclk) extIrqPin <= 1'b1;
    cyc(2);
    chk(serviceCount, base + 8'h03, "edge not yet served");
    cyc(4);
    chk(serviceCount, base + 8'h04, "rising edge served");
    rd(IDX_CTRL, 8'h12, RESP_OKAY);
    wr(IDX_OPTION, 8'hbf, RESP_OKAY);
    wr(IDX_CTRL, 8'h90, RESP_OKAY);
    @(posedge mclk) extIrqPin <= 1'b0;
    cyc(6);
    chk(serviceCount, base + 8'h05, "falling edge served");
    wr(IDX_CTRL, 8'h98, RESP_OKAY);
    pinAnalog <= 6'h04;
    @(posedge mclk) extIrqPin <= 1'b1;
    pulse(3, 8'h04);
    @(posedge mclk) extIrqPin <= 1'b0;
    cyc(6);
    rd(IDX_CTRL, 8'h98, RESP_OKAY);
    pinAnalog <= 6'h00;
    pulse(3, 8'h08);
    cyc(3);
    rd(IDX_CTRL, 8'h19, RESP_OKAY);
    $display("test pins done");
    wr(IDX_CTRL, 8'h10, RESP_OKAY);
    pulse(5, 8'h00);
    @(posedge mclk) extIrqPin <= 1'b1;
    cyc(6);
    chk({31'h0, coreSleeping}, 32'h0000_0001, "wrong edge keeps sleep");
    rd(IDX_STATUS, 8'h02, RESP_OKAY);
    @(posedge mclk) extIrqPin <= 1'b0;
    cyc(6);
    chk({31'h0, coreSleeping}, 32'h0000_0000, "edge wakes core");
    rd(IDX_CTRL, 8'h12, RESP_OKAY);
    chk(serviceCount, base + 8'h06, "no service with gie off");
    $display("test wake done");
    wr(IDX_CTRL, 8'h90, RESP_OKAY);
    @(posedge mclk) extIrqPin <= 1'b1;
    cyc(6);
    pulse(5, 8'h00);
    @(posedge mclk) extIrqPin <= 1'b0;
    cyc(6);
    chk({31'h0, coreSleeping}, 32'h0000_0000, "edge wakes core with gie set");
    chk(serviceCount, base + 8'h07, "wake-up with gie set is serviced");
    $display("test wake vector done");
    wr(IDX_CTRL, 8'hc0, RESP_OKAY);
    fork
      wr(IDX_CTRL, 8'h40, RESP_OKAY);
      pulse(1, 8'h40);
    join
    cyc(3);
    chk(serviceCount, base + 8'h07, "clearing gie defers request");
    rd(IDX_FLAGS1, 8'h40, RESP_OKAY);
    wr(IDX_CTRL, 8'hc0, RESP_OKAY);
    cyc(3);
    chk(serviceCount, base + 8'h08, "deferred request taken later");
    chk({24'h00_0000, reqCount}, 32'h0000_0009, "request cycles");
    $display("test deferral done");
    end_of_test();
  end
endmodule // tb
